// [logic/irq_timer_pkg.sv]
// Package for the board interrupt controller and interval timer.
// Assumes a single 40 MHz APB clock domain and 16-bit register contents.
`default_nettype none

package irq_timer_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TICK_PERIOD_PS = 99852000;
  localparam int TICK_CYCLES = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int DAC_UPLOAD_PS = 8000000;
  localparam int DAC_CYCLES = (DAC_UPLOAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Register indices; byte address is four times the index
  localparam logic [7:0] TIMER_CTRL_IDX = 8'h00;
  localparam logic [7:0] DAC_CTRL_IDX = 8'h04;
  localparam logic [7:0] ADC_CTRL_IDX = 8'h06;
  localparam logic [7:0] DIO_CTRL_IDX = 8'h0A;
  localparam logic [7:0] IRQ_ENABLE_IDX = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h0E;

  // Timer, DAC and DIO control fields
  localparam int TMR_PRELOAD_LSB = 8;
  localparam int TMR_AUTO_BIT = 1;
  localparam int TMR_RESTART_BIT = 0;
  localparam int TMR_RUN_BIT = 0;
  localparam int DAC_START_BIT = 0;
  localparam int DIO_GROUP_TWO_POL_BIT = 4;

  // Status layout
  localparam int ST_TIMER = 0;
  localparam int ST_DAC = 1;
  localparam int ST_ADC = 2;
  localparam int ST_DIO_LSB = 3;
  localparam int ST_CNT_LSB = 11;
  localparam int NUM_DIO = 8;
  localparam int NUM_CNT = 4;
  localparam int NUM_LOCAL = ST_CNT_LSB;
  localparam int NUM_SRC = NUM_LOCAL + NUM_CNT;

  localparam logic [7:0] TMR_RESET = 8'h00;
  localparam logic [NUM_SRC-1:0] ENABLE_RESET = 15'h0000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

endpackage : irq_timer_pkg

`default_nettype wire

// [logic/board_irq_timer.sv]
// Board interrupt controller with 8-bit interval timer, APB register slave.
// Assumes counter flags and ADC done come from logic on pclk; DIO lines are async pins.
`default_nettype none

// Functional notes
// - 8-bit down-counter from preload, one step per ~99.852 us tick.
// - Manual mode: counting starts on software restart and halts at zero.
// - Auto mode: reload preload and keep counting at every zero.
// - Expiry sets status bit 0; interrupts only with enable bit 0.
// - Expiry pulse goes to the counters as an output latch strobe.
// - One command uploads all four DAC buffers in ~8 us, then sets status.
// - ADC sequence completion sets its own status bit; its interrupt is gated by its enable.
// - DIO edges set status; polarity per line 0-3, shared for lines 4-7.
// - Status bits set on the condition regardless of enable.
// - Interrupt output high while any enabled status bit is set.
// - Writing zero to the enable register drops the interrupt output.
// - Counter status bits clear only in the counters, not via status writes.
// - Pending status reasserts interrupt as soon as enable is restored.
// - Writing one clears a status bit; writing zero leaves it.
// - Timer control bits 15:8 hold the preload in ~100 us ticks.
// - Bit 1 selects auto restart; bit 0 restarts only when bit 1 is clear.
// - Counter short events can request an interrupt when enabled.
module board_irq_timer
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire irq_timer_pkg::apb_req_type apb_req,
  output irq_timer_pkg::apb_rsp_type apb_rsp,
  // Event sources
  input wire logic adc_conv_done,
  input wire logic [irq_timer_pkg::NUM_CNT-1:0] cnt_event_flags,
  input wire logic [irq_timer_pkg::NUM_DIO-1:0] dio_lines,
  // Outputs to other blocks and host
  output logic cnt_latch_strobe,
  output logic dac_upload_start,
  output logic dac_upload_busy,
  output logic irq_out
);
  import irq_timer_pkg::*;

  typedef struct packed {
    logic [11:0] tick_cnt;
    logic [7:0] tmr_count;
    logic [7:0] tmr_preload;
    logic tmr_auto;
    logic tmr_run;
    logic strobe;
    logic dac_start;
    logic dac_busy;
    logic [8:0] dac_cnt;
    logic [NUM_DIO-1:0] dio_s1;
    logic [NUM_DIO-1:0] dio_s2;
    logic [NUM_DIO-1:0] dio_s3;
    logic [NUM_DIO-1:0] dio_stable;
    logic [4:0] dio_pol;
    logic [NUM_LOCAL-1:0] status;
    logic [NUM_SRC-1:0] enable;
    logic irq;
    logic ready;
    logic slverr;
    logic [31:0] prdata;
  } state_type;

  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
  localparam logic [8:0] DAC_LAST = 9'(DAC_CYCLES - 1);

  state_type state_reg;
  state_type state_next;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
    reg_hit = (addr == 8'(idx << 2));
  endfunction

  logic access;
  logic do_write;
  logic [15:0] wdata;
  logic [NUM_SRC-1:0] status_full;
  logic tick;
  logic expire;
  logic [NUM_DIO-1:0] dio_change;
  logic [NUM_DIO-1:0] dio_event;
  logic [NUM_LOCAL-1:0] set_bits;
  logic [NUM_LOCAL-1:0] clr_bits;
  logic mapped;
  logic [15:0] rd_word;

  always_comb
  begin
    state_next = state_reg;
    access = apb_req.psel && apb_req.penable;
    do_write = access && state_reg.ready && apb_req.pwrite;
    wdata = apb_req.pwdata[15:0];
    status_full = {cnt_event_flags, state_reg.status};
    set_bits = '0;
    clr_bits = '0;
    expire = 1'b0;
    dio_change = '0;
    dio_event = '0;
    mapped = 1'b0;
    rd_word = 16'h0000;

    // Time base runs free so intervals keep a fixed phase
    tick = (state_reg.tick_cnt == TICK_LAST);
    state_next.tick_cnt = tick ? 12'h000 : state_reg.tick_cnt + 12'h001;

    // Interval timer
    if (state_reg.tmr_run && tick)
    begin
      if (state_reg.tmr_count <= 8'h01)
      begin
        expire = 1'b1;
        if (state_reg.tmr_auto)
        begin
          state_next.tmr_count = state_reg.tmr_preload;
        end
        else
        begin
          state_next.tmr_count = TMR_RESET;
          state_next.tmr_run = 1'b0;
        end
      end
      else
      begin
        state_next.tmr_count = state_reg.tmr_count - 8'h01;
      end
    end
    state_next.strobe = expire;
    set_bits[ST_TIMER] = expire;

    // DAC upload sequencer
    state_next.dac_start = 1'b0;
    if (state_reg.dac_busy)
    begin
      if (state_reg.dac_cnt == DAC_LAST)
      begin
        state_next.dac_busy = 1'b0;
        set_bits[ST_DAC] = 1'b1;
      end
      else
      begin
        state_next.dac_cnt = state_reg.dac_cnt + 9'h001;
      end
    end
    set_bits[ST_ADC] = adc_conv_done;

    // DIO pins: three stages, a change counts once stages two and three agree
    state_next.dio_s1 = dio_lines;
    state_next.dio_s2 = state_reg.dio_s1;
    state_next.dio_s3 = state_reg.dio_s2;
    for (int i = 0; i < NUM_DIO; i++)
    begin
      dio_change[i] = (state_reg.dio_s2[i] == state_reg.dio_s3[i])
        && (state_reg.dio_s3[i] != state_reg.dio_stable[i]);
      if (i < 4)
      begin
        dio_event[i] = dio_change[i] && (state_reg.dio_s3[i] == state_reg.dio_pol[i]);
      end
      else
      begin
        dio_event[i] = dio_change[i]
          && (state_reg.dio_s3[i] == state_reg.dio_pol[DIO_GROUP_TWO_POL_BIT]);
      end
    end
    for (int i = 0; i < NUM_DIO; i++)
    begin
      if (dio_change[i])
      begin
        state_next.dio_stable[i] = state_reg.dio_s3[i];
      end
    end
    set_bits[ST_DIO_LSB +: NUM_DIO] = dio_event;

    // APB: one wait state, answer registered, writes at completion edge
    state_next.ready = 1'b0;
    state_next.slverr = 1'b0;
    if (access && !state_reg.ready)
    begin
      state_next.ready = 1'b1;
      if (reg_hit(apb_req.paddr, TIMER_CTRL_IDX))
      begin
        mapped = 1'b1;
        rd_word = {state_reg.tmr_count, 7'h00, state_reg.tmr_run};
      end
      if (reg_hit(apb_req.paddr, DAC_CTRL_IDX))
      begin
        mapped = 1'b1;
        rd_word = {15'h0000, state_reg.dac_busy};
      end
      if (reg_hit(apb_req.paddr, DIO_CTRL_IDX))
      begin
        mapped = 1'b1;
        rd_word = {3'h0, state_reg.dio_pol, state_reg.dio_stable};
      end
      if (reg_hit(apb_req.paddr, IRQ_ENABLE_IDX))
      begin
        mapped = 1'b1;
        rd_word = {1'b0, state_reg.enable};
      end
      if (reg_hit(apb_req.paddr, IRQ_STATUS_IDX))
      begin
        mapped = 1'b1;
        rd_word = {1'b0, status_full};
      end
      state_next.prdata = {16'h0000, rd_word};
      state_next.slverr = !mapped;
    end

    if (do_write)
    begin
      if (reg_hit(apb_req.paddr, TIMER_CTRL_IDX))
      begin
        state_next.tmr_preload = wdata[TMR_PRELOAD_LSB +: 8];
        state_next.tmr_auto = wdata[TMR_AUTO_BIT];
        if (wdata[TMR_AUTO_BIT])
        begin
          state_next.tmr_count = wdata[TMR_PRELOAD_LSB +: 8];
          state_next.tmr_run = 1'b1;
        end
        else if (wdata[TMR_RESTART_BIT])
        begin
          state_next.tmr_count = wdata[TMR_PRELOAD_LSB +: 8];
          state_next.tmr_run = 1'b1;
        end
        else
        begin
          state_next.tmr_run = 1'b0;
        end
      end
      if (reg_hit(apb_req.paddr, DAC_CTRL_IDX) && wdata[DAC_START_BIT] && !state_reg.dac_busy)
      begin
        state_next.dac_busy = 1'b1;
        state_next.dac_start = 1'b1;
        state_next.dac_cnt = 9'h000;
      end
      if (reg_hit(apb_req.paddr, DIO_CTRL_IDX))
      begin
        state_next.dio_pol = wdata[NUM_DIO +: 5];
      end
      if (reg_hit(apb_req.paddr, IRQ_ENABLE_IDX))
      begin
        state_next.enable = wdata[NUM_SRC-1:0];
      end
      if (reg_hit(apb_req.paddr, IRQ_STATUS_IDX))
      begin
        clr_bits = wdata[NUM_LOCAL-1:0];
      end
    end

    // New events win over a clear in the same cycle
    state_next.status = (state_reg.status & ~clr_bits) | set_bits;
    state_next.irq = |(status_full & state_reg.enable);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp.prdata = state_reg.prdata;
  assign apb_rsp.pready = state_reg.ready;
  assign apb_rsp.pslverr = state_reg.slverr;
  assign cnt_latch_strobe = state_reg.strobe;
  assign dac_upload_start = state_reg.dac_start;
  assign dac_upload_busy = state_reg.dac_busy;
  assign irq_out = state_reg.irq;

endmodule // board_irq_timer

`default_nettype wire

// [verif/board_irq_timer_properties.sv]
// Port checker for board_irq_timer.
// Assumes one pclk domain with asynchronous active-low presetn.
`default_nettype none
module board_irq_timer_properties
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire irq_timer_pkg::apb_req_type apb_req,
  input wire irq_timer_pkg::apb_rsp_type apb_rsp,
  // Outputs
  input wire logic cnt_latch_strobe,
  input wire logic dac_upload_start,
  input wire logic dac_upload_busy,
  input wire logic irq_out
);
  import irq_timer_pkg::*;
  logic [8:0] busy_len;
  logic [16:0] gap;
  // Gap waits for a first strobe and saturates so long idle spells never wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_len <= 9'h000;
      gap <= 17'h00000;
    end
    else
    begin
      busy_len <= dac_upload_busy ? busy_len + 9'h001 : 9'h000;
      gap <= cnt_latch_strobe ? 17'h00001 : ((gap == 0 || &gap) ? gap : gap + 17'h00001);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (apb_req.penable && !$past(apb_req.penable)
    |-> !apb_rsp.pready ##1 apb_rsp.pready) else $error("no single wait state");
  a_unmapped_err: assert property (apb_rsp.pready && apb_req.paddr == (ADC_CTRL_IDX << 2)
    |-> apb_rsp.pslverr) else $error("unmapped access not refused");
  a_upper_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_enable_off: assert property (
    apb_rsp.pready && apb_req.pwrite && apb_req.paddr == (IRQ_ENABLE_IDX << 2)
    && apb_req.pwdata[14:0] == 15'h0000 |-> ##2 !irq_out) else $error("irq stayed high");
  a_dac_length: assert property ($fell(dac_upload_busy) |-> busy_len == 9'h140)
    else $error("upload length wrong");
  a_dac_start: assert property (dac_upload_start |-> ##[0:1] dac_upload_busy)
    else $error("start without busy");
  a_strobe_pulse: assert property (cnt_latch_strobe |=> !cnt_latch_strobe)
    else $error("strobe longer than a cycle");
  a_tick_spacing: assert property (cnt_latch_strobe && gap != 0 && !(&gap)
    |-> gap % TICK_CYCLES == 0) else $error("expiry off the tick grid");
endmodule // board_irq_timer_properties

bind board_irq_timer board_irq_timer_properties board_irq_timer_properties_i (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .cnt_latch_strobe(cnt_latch_strobe), .dac_upload_start(dac_upload_start),
  .dac_upload_busy(dac_upload_busy), .irq_out(irq_out));
`default_nettype wire

// [verif/host_bus_model.sv]
// Host side model: APB master and the interrupt handler routine.
// Assumes the slave ends every transfer with pready; no latency is assumed.
`default_nettype none
module host_bus_model
(
  // Clock
  input wire logic pclk,
  // Bus
  output var irq_timer_pkg::apb_req_type apb_req,
  input wire irq_timer_pkg::apb_rsp_type apb_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_timer_pkg::*;
  logic [31:0] q;
  logic e;
  initial apb_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  // Disable first so the line drops, then clear what was seen and restore
  task automatic service(input logic [31:0] en);
    xfer(1'b1, IRQ_ENABLE_IDX << 2, 32'h0);
    xfer(1'b0, IRQ_STATUS_IDX << 2, 32'h0);
    xfer(1'b1, IRQ_STATUS_IDX << 2, q);
    xfer(1'b1, IRQ_ENABLE_IDX << 2, en);
  endtask
endmodule // host_bus_model
`default_nettype wire

// [verif/board_irq_timer_tb.sv]
// Testbench for board_irq_timer, driven through the host bus model.
// Assumes a 40 MHz pclk and the package register map.
`default_nettype none
module board_irq_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_timer_pkg::*;
  localparam logic [7:0] TC = TIMER_CTRL_IDX << 2;
  localparam logic [7:0] DC = DAC_CTRL_IDX << 2;
  localparam logic [7:0] DI = DIO_CTRL_IDX << 2;
  localparam logic [7:0] EN = IRQ_ENABLE_IDX << 2;
  localparam logic [7:0] ST = IRQ_STATUS_IDX << 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic adc_conv_done = 1'b0;
  logic [3:0] cnt_event_flags = 4'h0;
  logic [7:0] dio_lines = 8'h00;
  logic cnt_latch_strobe, dac_upload_start, dac_upload_busy, irq_out;
  apb_req_type apb_req;
  apb_rsp_type apb_rsp;
  int mismatches = 0;
  int samples_checked = 0;
  int n;
  board_irq_timer board_irq_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .adc_conv_done(adc_conv_done),
    .cnt_event_flags(cnt_event_flags),
    .dio_lines(dio_lines),
    .cnt_latch_strobe(cnt_latch_strobe),
    .dac_upload_start(dac_upload_start),
    .dac_upload_busy(dac_upload_busy),
    .irq_out(irq_out)
  );
  host_bus_model host_bus_model_i (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_bus_model_i.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host_bus_model_i.xfer(1'b0, a, 32'h0);
    chk(host_bus_model_i.q, exp);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic first_strobe();
    for (n = 0; cnt_latch_strobe !== 1'b1; n++) @(posedge pclk);
  endtask
  task automatic strobes(input int span);
    n = 0;
    repeat (span) @(posedge pclk) n += int'(cnt_latch_strobe === 1'b1);
  endtask
  task automatic close_out();
    $display("compared %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(25 * 80000);
    mismatches++;
    close_out();
  end
  initial
  begin
    settle(5);
    @(posedge pclk) presetn <= 1'b1;
    rd(EN, 32'h0);
    rd(ST, 32'h0);
    host_bus_model_i.xfer(1'b0, ADC_CTRL_IDX << 2, 32'h0);
    chk(host_bus_model_i.e, 1'b1);
    $display("done: reset and map");
    @(posedge pclk) adc_conv_done <= 1'b1;
    @(posedge pclk) adc_conv_done <= 1'b0;
    settle(3);
    rd(ST, 32'h4);
    chk(irq_out, 1'b0);
    wr(EN, 32'h4);
    settle(3);
    chk(irq_out, 1'b1);
    wr(EN, 32'h0);
    settle(3);
    chk(irq_out, 1'b0);
    wr(ST, 32'h0);
    rd(ST, 32'h4);
    wr(ST, 32'h4);
    rd(ST, 32'h0);
    $display("done: adc source");
    @(posedge pclk) cnt_event_flags <= 4'h5;
    settle(3);
    wr(ST, 32'h7FFF);
    rd(ST, 32'h2800);
    wr(EN, 32'h800);
    settle(3);
    chk(irq_out, 1'b1);
    @(posedge pclk) cnt_event_flags <= 4'h0;
    wr(DI, 32'h100);
    @(posedge pclk) dio_lines <= 8'h03;
    settle(8);
    @(posedge pclk) dio_lines <= 8'h00;
    settle(8);
    wr(DI, 32'h1000);
    @(posedge pclk) dio_lines <= 8'hF0;
    settle(8);
    rd(ST, 32'h798);
    rd(DI, 32'h10F0);
    wr(ST, 32'h7FF);
    wr(DC, 32'h1);
    rd(DC, 32'h1);
    settle(330);
    rd(ST, 32'h2);
    wr(ST, 32'h2);
    $display("done: counter, dio and dac");
    wr(EN, 32'h1);
    wr(TC, 32'h201);
    first_strobe();
    chk(n > TICK_CYCLES && n <= 2 * TICK_CYCLES + 2, 1'b1);
    settle(3);
    chk(irq_out, 1'b1);
    host_bus_model_i.service(32'h1);
    settle(3);
    chk(irq_out, 1'b0);
    strobes(2 * TICK_CYCLES + 10);
    chk(n, 0);
    rd(TC, 32'h0);
    wr(TC, 32'h102);
    first_strobe();
    strobes(2 * TICK_CYCLES + 2);
    chk(n, 2);
    wr(TC, 32'h0);
    $display("done: timer");
    close_out();
  end
endmodule // board_irq_timer_tb
`default_nettype wire
